// ---- verilog/clkgen_smbus_pkg.sv ----
// constants and types for the clock generator serial control slave
// Functional notes
// - control bytes load their defaults at reset
// - byte and block, read and write accepted
// - block bytes ascend from offset zero, MSB first
// - answer only address pattern 1101001 plus direction
// - command bit 7: 0 block, 1 single byte
// - command bits 4:0 give single-byte offset
// - block write: address, command, count, data, stop
// - block read: restart, read address, count, data
// - single write: address, command, one data byte
// - single read: restart, one byte, host nacks
// - byte 0 enables serial reference pairs
// - byte 1 enables single-ended and processor outputs
// - byte 2 bit 7 selects spread amount
// - byte 2 bits 6,5 select drive strengths
// - byte 2 bit 2 switches spread on
package clkgen_smbus_pkg;
	localparam logic [6:0] SLAVE_ADDR7 = 7'h69;
	localparam int CMD_SINGLE_BIT = 7;
	localparam int CS_MSB = 6;
	localparam int CS_LSB = 5;
	localparam logic [1:0] CS_MATCH = 2'h0;
	localparam int OFS_MSB = 4;
	localparam int NUM_REGS = 3;
	localparam logic [4:0] OFS_SERIAL_REF = 5'h00;
	localparam logic [4:0] OFS_SE_CPU = 5'h01;
	localparam logic [4:0] OFS_SPREAD = 5'h02;
	localparam logic [4:0] OFS_LIMIT = 5'h03;
	localparam logic [4:0] OFS_BLOCK_BASE = 5'h00;
	localparam logic [7:0] RST_SERIAL_REF = 8'hFF;
	localparam logic [7:0] RST_SE_CPU = 8'hFF;
	localparam logic [7:0] RST_SPREAD = 8'hEB;
	localparam logic [7:0] BLOCK_COUNT = 8'h03;
	localparam logic [7:0] SINGLE_COUNT = 8'h01;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int SER_PAIR_MSB = 7;
	localparam int SER_PAIR_LSB = 2;
	localparam int SEL_PAIR_MSB = 1;
	localparam int SEL_PAIR_LSB = 0;
	localparam int XREF_MSB = 7;
	localparam int XREF_LSB = 5;
	localparam int BUS33_OE_BIT = 4;
	localparam int USB48_OE_BIT = 3;
	localparam int CPU_PAIR_MSB = 1;
	localparam int CPU_PAIR_LSB = 0;
	localparam int SPREAD_AMT_BIT = 7;
	localparam int USB48_DRV_BIT = 6;
	localparam int BUS33_DRV_BIT = 5;
	localparam int SPREAD_EN_BIT = 2;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam int PIN_SDA = 0;
	localparam int PIN_SCL = 1;
	localparam int PIN_TGL = 2;
	localparam int PIN_W = 3;
	localparam logic [PIN_W-1:0] PIN_IDLE = 3'h3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_RX_ACK = 3'h3,
		ST_TX = 3'h2,
		ST_TX_ACK = 3'h6
	} state_t;
	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_CMD = 2'h1,
		PH_COUNT = 2'h3,
		PH_DATA = 2'h2
	} phase_t;
endpackage : clkgen_smbus_pkg

// ---- verilog/clkgen_smbus_if.sv ----
// interfaces joining the serial core with its sampler and register file
`timescale 1ns/100ps
`default_nettype none
interface link_bit_if;
	logic bit_val;
	logic bit_tgl;
	modport link (output bit_val, output bit_tgl);
	modport core (input bit_val, input bit_tgl);
endinterface : link_bit_if

interface reg_port_if;
	import clkgen_smbus_pkg::*;
	logic wr_en;
	logic [4:0] wr_ofs;
	logic [7:0] wr_data;
	logic [NUM_REGS-1:0][7:0] rd_bytes;
	modport regs (input wr_en, input wr_ofs, input wr_data,
		output rd_bytes);
	modport core (output wr_en, output wr_ofs, output wr_data,
		input rd_bytes);
endinterface : reg_port_if
`default_nettype wire

// ---- verilog/smbus_link_sampler.sv ----
// serial clock domain: samples each data bit on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module smbus_link_sampler (
	input wire logic scl_i,
	input wire logic rst_i,
	input wire logic sda_i,
	link_bit_if.link lnk
);
	typedef struct packed {
		logic bit_val;
		logic bit_tgl;
	} link_state_t;
	link_state_t s_q;
	link_state_t s_d;

	// data held until the next rising edge, toggle marks a new bit
	always_comb
	begin
		s_d = s_q;
		s_d.bit_val = sda_i;
		s_d.bit_tgl = ~s_q.bit_tgl;
	end

	always_ff @(posedge scl_i or posedge rst_i)
	begin
		if (rst_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign lnk.bit_val = s_q.bit_val;
	assign lnk.bit_tgl = s_q.bit_tgl;
endmodule : smbus_link_sampler
`default_nettype wire

// ---- verilog/clkgen_ctrl_regs.sv ----
// the three clock control bytes and the controls they drive
`timescale 1ns/100ps
`default_nettype none
module clkgen_ctrl_regs
	import clkgen_smbus_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	reg_port_if.regs rp,
	output logic [5:0] serial_ref_pair_oe_o,
	output logic [1:0] selectable_ref_pair_oe_o,
	output logic [2:0] crystal_ref_out_oe_o,
	output logic bus33_clock_oe_o,
	output logic usb48_oe_o,
	output logic [1:0] cpu_pair_oe_o,
	output logic spread_amount_sel_o,
	output logic usb48_drive_2x_o,
	output logic bus33_drive_2x_o,
	output logic spread_enable_o
);
	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] bytes;
	} regs_state_t;
	regs_state_t s_q;
	regs_state_t s_d;

	// whole bytes stored, reserved bits included, unmapped offsets dropped
	always_comb
	begin
		s_d = s_q;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			if (rp.wr_en && rp.wr_ofs == 5'(i))
				s_d.bytes[i] = rp.wr_data;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_q.bytes[OFS_SERIAL_REF] <= RST_SERIAL_REF;
			s_q.bytes[OFS_SE_CPU] <= RST_SE_CPU;
			s_q.bytes[OFS_SPREAD] <= RST_SPREAD;
		end
		else
			s_q <= s_d;
	end

	assign rp.rd_bytes = s_q.bytes;
	assign serial_ref_pair_oe_o =
		s_q.bytes[OFS_SERIAL_REF][SER_PAIR_MSB:SER_PAIR_LSB];
	assign selectable_ref_pair_oe_o =
		s_q.bytes[OFS_SERIAL_REF][SEL_PAIR_MSB:SEL_PAIR_LSB];
	assign crystal_ref_out_oe_o =
		s_q.bytes[OFS_SE_CPU][XREF_MSB:XREF_LSB];
	assign bus33_clock_oe_o = s_q.bytes[OFS_SE_CPU][BUS33_OE_BIT];
	assign usb48_oe_o = s_q.bytes[OFS_SE_CPU][USB48_OE_BIT];
	assign cpu_pair_oe_o =
		s_q.bytes[OFS_SE_CPU][CPU_PAIR_MSB:CPU_PAIR_LSB];
	assign spread_amount_sel_o =
		s_q.bytes[OFS_SPREAD][SPREAD_AMT_BIT];
	assign usb48_drive_2x_o = s_q.bytes[OFS_SPREAD][USB48_DRV_BIT];
	assign bus33_drive_2x_o = s_q.bytes[OFS_SPREAD][BUS33_DRV_BIT];
	assign spread_enable_o = s_q.bytes[OFS_SPREAD][SPREAD_EN_BIT];
endmodule : clkgen_ctrl_regs
`default_nettype wire

// ---- verilog/clkgen_smbus_slave.sv ----
// serial control slave of the clock generator: protocol core and top
`timescale 1ns/100ps
`default_nettype none
module clkgen_smbus_slave (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [5:0] serial_ref_pair_oe_o,
	output logic [1:0] selectable_ref_pair_oe_o,
	output logic [2:0] crystal_ref_out_oe_o,
	output logic bus33_clock_oe_o,
	output logic usb48_oe_o,
	output logic [1:0] cpu_pair_oe_o,
	output logic spread_amount_sel_o,
	output logic usb48_drive_2x_o,
	output logic bus33_drive_2x_o,
	output logic spread_enable_o
);
	import clkgen_smbus_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0] sy1;
		logic [PIN_W-1:0] sy2;
		logic [PIN_W-1:0] sy3;
		logic [PIN_W-1:0] flt;
		state_t st;
		phase_t ph;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [4:0] ptr;
		logic [7:0] left;
		logic rd_mode;
		logic count_next;
		logic wr_ok;
		logic oe;
		logic wr_en;
		logic [4:0] wr_ofs;
		logic [7:0] wr_data;
	} core_t;

	core_t s_q;
	core_t s_d;

	link_bit_if lnk ();
	reg_port_if rp ();

	smbus_link_sampler u_sampler (
		.scl_i (scl_i),
		.rst_i (rst_i),
		.sda_i (sda_i),
		.lnk (lnk.link)
	);

	clkgen_ctrl_regs u_regs (
		.mclk_i (mclk_i),
		.rst_i (rst_i),
		.rp (rp.regs),
		.serial_ref_pair_oe_o (serial_ref_pair_oe_o),
		.selectable_ref_pair_oe_o (selectable_ref_pair_oe_o),
		.crystal_ref_out_oe_o (crystal_ref_out_oe_o),
		.bus33_clock_oe_o (bus33_clock_oe_o),
		.usb48_oe_o (usb48_oe_o),
		.cpu_pair_oe_o (cpu_pair_oe_o),
		.spread_amount_sel_o (spread_amount_sel_o),
		.usb48_drive_2x_o (usb48_drive_2x_o),
		.bus33_drive_2x_o (bus33_drive_2x_o),
		.spread_enable_o (spread_enable_o)
	);

	// byte returned for an offset, zero beyond the map
	function automatic logic [7:0] read_byte(
		input logic [4:0] ofs,
		input logic [NUM_REGS-1:0][7:0] bytes
	);
		logic [7:0] r;
		r = UNMAPPED_READ;
		if (ofs < OFS_LIMIT)
			r = bytes[ofs[1:0]];
		return r;
	endfunction : read_byte

	// new pin levels, old level kept while stages two and three differ
	function automatic logic [PIN_W-1:0] filter_pins(
		input logic [PIN_W-1:0] st2,
		input logic [PIN_W-1:0] st3,
		input logic [PIN_W-1:0] held
	);
		logic [PIN_W-1:0] r;
		r = held;
		for (int i = 0; i < PIN_W; i++)
		begin
			if (st2[i] == st3[i])
				r[i] = st3[i];
		end
		return r;
	endfunction : filter_pins

	// address byte names this slave, either direction
	function automatic logic own_address(input logic [7:0] b);
		return b[7:1] == SLAVE_ADDR7;
	endfunction : own_address

	// command carries this device's chip-select field
	function automatic logic chip_selected(input logic [7:0] c);
		return c[CS_MSB:CS_LSB] == CS_MATCH;
	endfunction : chip_selected

	// eighth bit of a byte reached
	function automatic logic last_bit(input logic [3:0] c);
		return c == LAST_DATA_BIT;
	endfunction : last_bit

	// slave pulls the line for an ack slot or a zero data bit
	function automatic logic drive_low(
		input state_t st,
		input logic msb
	);
		return (st == ST_RX_ACK) || (st == ST_TX && !msb);
	endfunction : drive_low

	always_comb
	begin
		logic [PIN_W-1:0] flt_n;
		logic bit_evt;
		logic scl_fall;
		logic start_cond;
		logic stop_cond;
		logic [7:0] byte_in;
		flt_n = s_q.flt;
		bit_evt = 1'b0;
		scl_fall = 1'b0;
		start_cond = 1'b0;
		stop_cond = 1'b0;
		byte_in = {s_q.sh[6:0], lnk.bit_val};
		s_d = s_q;
		s_d.wr_en = 1'b0;

		// three-stage capture; a change counts once stages two and three agree
		s_d.sy1 = {lnk.bit_tgl, scl_i, sda_i};
		s_d.sy2 = s_q.sy1;
		s_d.sy3 = s_q.sy2;
		flt_n = filter_pins(s_q.sy2, s_q.sy3, s_q.flt);
		s_d.flt = flt_n;

		bit_evt = flt_n[PIN_TGL] != s_q.flt[PIN_TGL];
		scl_fall = s_q.flt[PIN_SCL] & ~flt_n[PIN_SCL];
		start_cond = s_q.flt[PIN_SCL] & flt_n[PIN_SCL] &
			s_q.flt[PIN_SDA] & ~flt_n[PIN_SDA];
		stop_cond = s_q.flt[PIN_SCL] & flt_n[PIN_SCL] &
			~s_q.flt[PIN_SDA] & flt_n[PIN_SDA];

		if (start_cond)
		begin
			// start and repeated start both reopen the address phase
			s_d.st = ST_RX;
			s_d.ph = PH_ADDR;
			s_d.cnt = 4'h0;
			s_d.oe = 1'b0;
		end
		else if (stop_cond)
		begin
			s_d.st = ST_IDLE;
			s_d.oe = 1'b0;
		end
		else
		begin
			if (bit_evt)
			begin
				unique case (s_q.st)
					ST_IDLE:
					begin
						s_d.cnt = 4'h0;
					end
					ST_RX:
					begin
						s_d.sh = byte_in;
						s_d.cnt = s_q.cnt + 4'h1;
						if (last_bit(s_q.cnt))
						begin
							s_d.st = ST_RX_ACK;
							unique case (s_q.ph)
								PH_ADDR:
								begin
									if (own_address(byte_in))
									begin
										s_d.rd_mode = byte_in[0];
										s_d.ph = PH_CMD;
										// block read opens with the count
										s_d.count_next = byte_in[0] &
											~s_q.cmd[CMD_SINGLE_BIT];
									end
									else
										s_d.st = ST_IDLE;
								end
								PH_CMD:
								begin
									s_d.cmd = byte_in;
									s_d.wr_ok = chip_selected(byte_in);
									if (byte_in[CMD_SINGLE_BIT])
									begin
										s_d.ptr = byte_in[OFS_MSB:0];
										s_d.left = SINGLE_COUNT;
										s_d.ph = PH_DATA;
									end
									else
									begin
										s_d.ptr = OFS_BLOCK_BASE;
										s_d.ph = PH_COUNT;
									end
								end
								PH_COUNT:
								begin
									s_d.left = byte_in;
									s_d.ph = PH_DATA;
								end
								PH_DATA:
								begin
									if (s_q.left != 8'h00)
									begin
										s_d.wr_en = s_q.wr_ok;
										s_d.wr_ofs = s_q.ptr;
										s_d.wr_data = byte_in;
										s_d.ptr = s_q.ptr + 5'h01;
										s_d.left = s_q.left - 8'h01;
									end
									else
										s_d.st = ST_IDLE;
								end
							endcase
						end
					end
					ST_RX_ACK:
					begin
						s_d.cnt = 4'h0;
						if (s_q.rd_mode)
						begin
							s_d.st = ST_TX;
							if (s_q.count_next)
								s_d.sh = BLOCK_COUNT;
							else
							begin
								s_d.sh = read_byte(s_q.ptr, rp.rd_bytes);
								s_d.ptr = s_q.ptr + 5'h01;
							end
							s_d.count_next = 1'b0;
						end
						else
							s_d.st = ST_RX;
					end
					ST_TX:
					begin
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.cnt = s_q.cnt + 4'h1;
						if (last_bit(s_q.cnt))
							s_d.st = ST_TX_ACK;
					end
					ST_TX_ACK:
					begin
						// host ack asks for the next byte, a nack ends the read
						if (!lnk.bit_val)
						begin
							s_d.st = ST_TX;
							s_d.cnt = 4'h0;
							s_d.sh = read_byte(s_q.ptr, rp.rd_bytes);
							s_d.ptr = s_q.ptr + 5'h01;
						end
						else
							s_d.st = ST_IDLE;
					end
					default:
					begin
						s_d.st = ST_IDLE;
					end
				endcase
			end
			// the data line only moves while the clock is low
			if (scl_fall)
				s_d.oe = drive_low(s_q.st, s_q.sh[7]);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
			s_q.sy1 <= PIN_IDLE;
			s_q.sy2 <= PIN_IDLE;
			s_q.sy3 <= PIN_IDLE;
			s_q.flt <= PIN_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign rp.wr_en = s_q.wr_en;
	assign rp.wr_ofs = s_q.wr_ofs;
	assign rp.wr_data = s_q.wr_data;
	assign sda_o = 1'b0;
	assign sda_oe_o = s_q.oe;
endmodule : clkgen_smbus_slave
`default_nettype wire

// ---- bench/clkgen_smbus_properties.sv ----
// port checks of the clock generator serial control slave
`timescale 1ns/100ps
`default_nettype none
module clkgen_smbus_properties
	import clkgen_smbus_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [5:0] serial_ref_pair_oe_o,
	input wire logic [1:0] selectable_ref_pair_oe_o,
	input wire logic [2:0] crystal_ref_out_oe_o,
	input wire logic bus33_clock_oe_o,
	input wire logic usb48_oe_o,
	input wire logic [1:0] cpu_pair_oe_o,
	input wire logic spread_amount_sel_o,
	input wire logic usb48_drive_2x_o,
	input wire logic bus33_drive_2x_o,
	input wire logic spread_enable_o
);
	localparam logic [18:0] DFLT = {RST_SERIAL_REF, RST_SE_CPU[7:3],
		RST_SE_CPU[1:0], RST_SPREAD[7:5], RST_SPREAD[2]};
	logic [3:0] nb_q;
	logic [7:0] sh_q;
	logic first_q;
	logic [18:0] regs;
	assign regs = {serial_ref_pair_oe_o, selectable_ref_pair_oe_o,
		crystal_ref_out_oe_o, bus33_clock_oe_o, usb48_oe_o, cpu_pair_oe_o,
		spread_amount_sel_o, usb48_drive_2x_o, bus33_drive_2x_o,
		spread_enable_o};
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	sequence start_s;
		scl_i && $fell(sda_i);
	endsequence
	sequence addr_end_s;
		first_q && nb_q == 4'h8;
	endsequence
	// tracks the address byte after each start
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			nb_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'h0;
		end
		else if (scl_i && $fell(sda_i))
		begin
			nb_q <= 4'h0;
			first_q <= 1'h1;
		end
		else if ($rose(scl_i))
		begin
			nb_q <= (nb_q == 4'h8) ? 4'h0 : nb_q + 4'h1;
			sh_q <= {sh_q[6:0], sda_i};
			first_q <= first_q && nb_q != 4'h8;
		end
	end
	reset_defaults_a:
		assert property ($fell(rst_i) |-> regs == DFLT)
		else $error("outputs not at defaults");
	open_drain_a:
		assert property (sda_o == 1'h0)
		else $error("data line driven high");
	ack_after_fall_a:
		assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("drive began outside clock low");
	drive_stands_a:
		assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*8])
		else $error("drive moved while clock high");
	addr_ack_a:
		assert property (addr_end_s ##0 ($fell(scl_i) &&
			sh_q[7:1] == SLAVE_ADDR7) |-> ##[1:8] sda_oe_o)
		else $error("own address not acknowledged");
	addr_refuse_a:
		assert property (addr_end_s ##0 sh_q[7:1] != SLAVE_ADDR7 |-> !sda_oe_o)
		else $error("foreign address acknowledged");
	start_quiet_a:
		assert property (start_s |=> !sda_oe_o [*8])
		else $error("drive right after start");
	regs_settle_a:
		assert property (!$stable(regs) |-> scl_i && $past(scl_i, 3))
		else $error("controls changed off a data bit");
endmodule : clkgen_smbus_properties
`default_nettype wire

// ---- bench/smbus_host.sv ----
// serial host model for the clock generator control slave
`timescale 1ns/100ps
`default_nettype none
module smbus_host (
	output logic scl_o,
	output logic sda_oe_o,
	input wire logic sda_i
);
	localparam time Q = 300ns;
	initial
	begin
		scl_o = 1'h1;
		sda_oe_o = 1'h0;
	end
	// data set while clock low, sampled mid high
	task automatic bit_x(input logic b, output logic s);
		#Q sda_oe_o = ~b;
		#Q scl_o = 1'h1;
		#Q s = sda_i;
		#Q scl_o = 1'h0;
	endtask : bit_x
	task automatic start();
		#Q sda_oe_o = 1'h0;
		#Q scl_o = 1'h1;
		#Q sda_oe_o = 1'h1;
		#Q scl_o = 1'h0;
	endtask : start
	task automatic tx(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'h1, s);
		ack = ~s;
	endtask : tx
	task automatic rx(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'h1, s);
			d[i] = s;
		end
		bit_x(last, s);
	endtask : rx
	task automatic stop();
		#Q sda_oe_o = 1'h1;
		#Q scl_o = 1'h1;
		#Q sda_oe_o = 1'h0;
		#Q;
	endtask : stop
endmodule : smbus_host
`default_nettype wire

// ---- bench/clock_gen_smbus_config_slave_bench.sv ----
// testbench of the clock generator serial control slave
`timescale 1ns/100ps
`default_nettype none
module clock_gen_smbus_config_slave_bench;
	logic mclk_i = 1'h0;
	// left unknown so the first drive gives both domains a reset edge
	logic rst_i;
	wire scl_i;
	wire sda_i;
	logic sda_o, sda_oe_o, host_oe;
	logic [5:0] serial_ref_pair_oe_o;
	logic [1:0] selectable_ref_pair_oe_o, cpu_pair_oe_o;
	logic [2:0] crystal_ref_out_oe_o;
	logic bus33_clock_oe_o, usb48_oe_o, spread_amount_sel_o;
	logic usb48_drive_2x_o, bus33_drive_2x_o, spread_enable_o;
	int fails = 0;
	int check_count = 0;
	assign sda_i = ~(host_oe | sda_oe_o);
	always #5 mclk_i = ~mclk_i;
	clkgen_smbus_slave u_clkgen_smbus_slave (.*);
	smbus_host u_smbus_host (.scl_o(scl_i), .sda_oe_o(host_oe), .sda_i(sda_i));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic outs(input logic [7:0] b0, b1, b2);
		@(negedge mclk_i);
		check({serial_ref_pair_oe_o, selectable_ref_pair_oe_o}, b0);
		check({crystal_ref_out_oe_o, bus33_clock_oe_o, usb48_oe_o, 1'h0,
			cpu_pair_oe_o}, b1 & 8'hFB);
		check({spread_amount_sel_o, usb48_drive_2x_o, bus33_drive_2x_o, 2'h0,
			spread_enable_o, 2'h0}, b2 & 8'hE4);
	endtask : outs
	task automatic wb(input logic [7:0] d, input logic ak);
		logic a;
		u_smbus_host.tx(d, a);
		check({7'h0, a}, {7'h0, ak});
	endtask : wb
	task automatic hdr(input logic [7:0] cmd);
		@(posedge mclk_i);
		#3;
		u_smbus_host.start();
		wb(8'hD2, 1'h1);
		wb(cmd, 1'h1);
	endtask : hdr
	task automatic rd(input logic [7:0] cmd);
		hdr(cmd);
		u_smbus_host.start();
		wb(8'hD3, 1'h1);
	endtask : rd
	task automatic rb(input logic last, input logic [7:0] e);
		logic [7:0] d;
		u_smbus_host.rx(last, d);
		check(d, e);
	endtask : rb
	task automatic t_reset();
		rst_i <= 1'h1;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge mclk_i);
		outs(8'hFF, 8'hFF, 8'hEB);
	endtask : t_reset
	task automatic t_single();
		logic [7:0] v [3];
		v = '{8'h5A, 8'hA4, 8'h24};
		for (int i = 0; i < 3; i++)
		begin
			hdr({3'h4, i[4:0]});
			wb(v[i], 1'h1);
			wb(8'h11, 1'h0);
			u_smbus_host.stop();
			rd({3'h4, i[4:0]});
			rb(1'h1, v[i]);
			u_smbus_host.stop();
		end
		outs(v[0], v[1], v[2]);
	endtask : t_single
	task automatic t_block();
		hdr(8'h00);
		wb(8'h03, 1'h1);
		wb(8'hC3, 1'h1);
		wb(8'h3C, 1'h1);
		wb(8'h99, 1'h1);
		wb(8'h77, 1'h0);
		u_smbus_host.stop();
		outs(8'hC3, 8'h3C, 8'h99);
		hdr(8'h00);
		wb(8'h02, 1'h1);
		wb(8'h0F, 1'h1);
		u_smbus_host.stop();
		rd(8'h00);
		rb(1'h0, 8'h03);
		rb(1'h0, 8'h0F);
		rb(1'h0, 8'h3C);
		rb(1'h1, 8'h99);
		u_smbus_host.stop();
	endtask : t_block
	task automatic t_refuse();
		@(posedge mclk_i);
		#3;
		u_smbus_host.start();
		wb(8'hD4, 1'h0);
		u_smbus_host.stop();
		hdr(8'hA0);
		wb(8'h00, 1'h1);
		u_smbus_host.stop();
		hdr(8'h83);
		wb(8'h55, 1'h1);
		u_smbus_host.stop();
		rd(8'h83);
		rb(1'h1, 8'h00);
		u_smbus_host.stop();
		outs(8'h0F, 8'h3C, 8'h99);
	endtask : t_refuse
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#1ms;
		fails++;
		report_and_stop();
	end
	initial
	begin
		t_reset();
		t_single();
		t_block();
		t_refuse();
		@(posedge mclk_i);
		t_reset();
		report_and_stop();
	end
endmodule : clock_gen_smbus_config_slave_bench
bind clkgen_smbus_slave clkgen_smbus_properties u_clkgen_smbus_properties (.*);
`default_nettype wire
